// >>> src/mas_sequencer.sv
// Masked add and circular shift sequencer with APB register access
//
// Added by the designer: the address map and the APB register port.
module mas_sequencer
   import mas_pkg::*;
(
   // Clock and reset
   input  wire logic                     I_MCLK,
   input  wire logic                     I_RESETN,
   // APB slave
   input  wire logic                     I_PSEL,
   input  wire logic                     I_PENABLE,
   input  wire logic                     I_PWRITE,
   input  wire logic [7:0]               I_PADDR,
   input  wire logic [31:0]              I_PWDATA,
   output logic      [31:0]              O_PRDATA,
   output logic                          O_PREADY,
   output logic                          O_PSLVERR,
   // Commands from the command timing control
   input  wire logic                     I_INIT_LOGICAL,
   input  wire logic                     I_EXTEND_SEQ,
   input  wire logic                     I_INIT_SHIFT_A,
   input  wire logic                     I_INIT_SHIFT_Q,
   input  wire logic                     I_CTL_CLOCK,
   input  wire logic                     I_SC_LOAD,
   input  wire logic [mas_pkg::SC_W-1:0] I_SC_VALUE,
   // Answers to the command timing control
   output logic                          O_RESUME,
   output logic                          O_WAIT_SHIFT,
   output logic                          O_BUSY
);
   import mas_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [ACC_W-1:0] acc_ff;
   logic [Q_W-1:0]   q_ff;
   logic [Q_W-1:0]   x_ff;
   logic [Q_W-1:0]   addend_ff;
   logic [SC_W-1:0]  sc_ff;
   mas_step_e        step_ff;
   logic             delayed_add_ff;
   logic             logical_ff;
   logic             extend_ff;
   logic             restore_x_ff;
   logic             final_ff;
   logic             a_shift_ff;
   logic             q_shift_ff;
   logic             resume_ff;
   logic             wait_shift_ff;
   logic             busy_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;

   logic [ACC_W-1:0] nxt_acc;
   logic [Q_W-1:0]   nxt_q;
   logic [Q_W-1:0]   nxt_x;
   logic [SC_W-1:0]  nxt_sc;
   mas_step_e        nxt_step;

   mas_dp_if dp_bus ();

   mas_datapath u_datapath (
      .dp (dp_bus.dp)
   );

   assign dp_bus.acc    = acc_ff;
   assign dp_bus.addend = addend_ff;
   assign dp_bus.qreg   = q_ff;

   ////////////////////////////////////////////////////////////////////////
   // Command decode; new commands are ignored while a sequence runs
   wire busy          = logical_ff | a_shift_ff | q_shift_ff;
   wire sc_nonzero    = (sc_ff != SC_ZERO);
   wire start_logical = I_INIT_LOGICAL & ~busy;
   wire start_extend  = I_EXTEND_SEQ & ~busy;
   wire start_shift_a = I_INIT_SHIFT_A & ~busy & ~I_INIT_LOGICAL & sc_nonzero;
   wire start_shift_q = I_INIT_SHIFT_Q & ~busy & ~I_INIT_LOGICAL & ~I_INIT_SHIFT_A
                        & sc_nonzero;
   wire sc_load       = I_SC_LOAD & ~busy;
   wire step_pulse    = I_CTL_CLOCK & (step_ff != STEP_IDLE);
   wire at_step1      = step_pulse & (step_ff == STEP_1);
   wire at_step2      = step_pulse & (step_ff == STEP_2);
   wire at_step3      = step_pulse & (step_ff == STEP_3);
   wire at_step4      = step_pulse & (step_ff == STEP_4);
   wire at_step5      = step_pulse & (step_ff == STEP_5);
   wire at_step6      = step_pulse & (step_ff == STEP_6);
   wire shift_a_pulse = I_CTL_CLOCK & a_shift_ff;
   wire shift_q_pulse = I_CTL_CLOCK & q_shift_ff;
   wire shift_pulse   = shift_a_pulse | shift_q_pulse;
   wire shift_end     = shift_pulse & (sc_ff == SC_LAST);

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, data and error prepared in setup
   wire apb_setup  = I_PSEL & ~I_PENABLE;
   wire hit_a_lo   = (I_PADDR == OFS_A_LO);
   wire hit_a_mid  = (I_PADDR == OFS_A_MID);
   wire hit_a_hi   = (I_PADDR == OFS_A_HI);
   wire hit_q_lo   = (I_PADDR == OFS_Q_LO);
   wire hit_q_hi   = (I_PADDR == OFS_Q_HI);
   wire hit_x_lo   = (I_PADDR == OFS_X_LO);
   wire hit_x_hi   = (I_PADDR == OFS_X_HI);
   wire hit_sc     = (I_PADDR == OFS_SC);
   wire hit_status = (I_PADDR == OFS_STATUS);
   wire hit_any    = hit_a_lo | hit_a_mid | hit_a_hi | hit_q_lo | hit_q_hi
                     | hit_x_lo | hit_x_hi | hit_sc | hit_status;
   // Writes while a sequence runs would corrupt it, so they are dropped
   wire apb_wr     = I_PSEL & I_PENABLE & I_PWRITE & pready_ff & hit_any & ~busy;

   wire [31:0] status_word = {21'h0, step_ff, busy,
                              q_shift_ff, a_shift_ff, final_ff, restore_x_ff,
                              extend_ff, logical_ff, delayed_add_ff};

   wire [31:0] rd_word =
        hit_a_lo   ? acc_ff[31:0] :
        hit_a_mid  ? acc_ff[63:32] :
        hit_a_hi   ? {24'h0, acc_ff[71:64]} :
        hit_q_lo   ? q_ff[31:0] :
        hit_q_hi   ? {28'h0, q_ff[35:32]} :
        hit_x_lo   ? x_ff[31:0] :
        hit_x_hi   ? {28'h0, x_ff[35:32]} :
        hit_sc     ? {25'h0, sc_ff} :
        hit_status ? status_word :
                     32'h0;

   wire [31:0] nxt_prdata  = (apb_setup & ~I_PWRITE) ? rd_word : 32'h0;
   wire        nxt_pslverr = apb_setup & ~hit_any;

   ////////////////////////////////////////////////////////////////////////
   // Next accumulator
   always_comb begin
      nxt_acc = acc_ff;
      if (at_step2) begin
         nxt_acc = dp_bus.acc_sum;
      end else if (shift_a_pulse) begin
         nxt_acc = dp_bus.acc_rot;
      end else if (apb_wr & hit_a_lo) begin
         nxt_acc[31:0] = I_PWDATA;
      end else if (apb_wr & hit_a_mid) begin
         nxt_acc[63:32] = I_PWDATA;
      end else if (apb_wr & hit_a_hi) begin
         nxt_acc[71:64] = I_PWDATA[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next Q
   always_comb begin
      nxt_q = q_ff;
      if (at_step4) begin
         nxt_q = RST_Q;
      end else if (at_step6) begin
         nxt_q = x_ff;
      end else if (shift_q_pulse) begin
         nxt_q = dp_bus.q_rot;
      end else if (apb_wr & hit_q_lo) begin
         nxt_q[31:0] = I_PWDATA;
      end else if (apb_wr & hit_q_hi) begin
         nxt_q[35:32] = I_PWDATA[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next X; the complement-transfer from Q leaves X AND Q in X
   always_comb begin
      nxt_x = x_ff;
      if (start_logical) begin
         nxt_x = x_ff & q_ff;
      end else if (at_step2) begin
         nxt_x = RST_X;
      end else if (at_step3) begin
         nxt_x = ~RST_X;
      end else if (at_step4) begin
         nxt_x = x_ff & q_ff;
      end else if (at_step5) begin
         nxt_x = ~x_ff;
      end else if (at_step6) begin
         nxt_x = RST_X;
      end else if (apb_wr & hit_x_lo) begin
         nxt_x[31:0] = I_PWDATA;
      end else if (apb_wr & hit_x_hi) begin
         nxt_x[35:32] = I_PWDATA[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next shift counter; the load pin wins over a register write
   always_comb begin
      nxt_sc = sc_ff;
      if (shift_pulse) begin
         nxt_sc = sc_ff - SC_STEP;
      end else if (sc_load) begin
         nxt_sc = I_SC_VALUE;
      end else if (apb_wr & hit_sc) begin
         nxt_sc = I_PWDATA[SC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Probe step order, one step per controlled clock pulse
   always_comb begin
      nxt_step = step_ff;
      unique case (step_ff)
         STEP_IDLE: begin
            if (start_logical) begin
               nxt_step = STEP_1;
            end
         end
         STEP_1: begin
            if (at_step1) begin
               nxt_step = STEP_2;
            end
         end
         STEP_2: begin
            if (at_step2) begin
               nxt_step = STEP_3;
            end
         end
         STEP_3: begin
            if (at_step3) begin
               nxt_step = STEP_4;
            end
         end
         STEP_4: begin
            if (at_step4) begin
               nxt_step = STEP_5;
            end
         end
         STEP_5: begin
            if (at_step5) begin
               nxt_step = STEP_6;
            end
         end
         STEP_6: begin
            if (at_step6) begin
               nxt_step = STEP_IDLE;
            end
         end
         default: begin
            nxt_step = STEP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag next values
   wire nxt_delayed_add = start_logical | (delayed_add_ff & ~at_step1);
   wire nxt_logical     = start_logical | (logical_ff & ~at_step6);
   wire nxt_extend      = start_extend | (extend_ff & ~at_step4);
   wire nxt_restore_x   = at_step2 | (restore_x_ff & ~at_step3);
   wire nxt_final       = at_step5 | (final_ff & ~at_step6);
   wire nxt_a_shift     = start_shift_a | (a_shift_ff & ~shift_end);
   wire nxt_q_shift     = start_shift_q | (q_shift_ff & ~shift_end);
   wire nxt_resume      = at_step6 | shift_end;
   wire nxt_wait_shift  = start_shift_a | start_shift_q;
   wire nxt_busy        = nxt_logical | nxt_a_shift | nxt_q_shift;

   ////////////////////////////////////////////////////////////////////////
   // Datapath registers
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         acc_ff    <= RST_ACC;
         q_ff      <= RST_Q;
         x_ff      <= RST_X;
         addend_ff <= RST_X;
         sc_ff     <= RST_SC;
      end else begin
         acc_ff    <= nxt_acc;
         q_ff      <= nxt_q;
         x_ff      <= nxt_x;
         addend_ff <= at_step1 ? x_ff : addend_ff;
         sc_ff     <= nxt_sc;
      end
   end

   // Sequence control
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         step_ff        <= STEP_IDLE;
         delayed_add_ff <= 1'b0;
         logical_ff     <= 1'b0;
         extend_ff      <= 1'b0;
         restore_x_ff   <= 1'b0;
         final_ff       <= 1'b0;
         a_shift_ff     <= 1'b0;
         q_shift_ff     <= 1'b0;
      end else begin
         step_ff        <= nxt_step;
         delayed_add_ff <= nxt_delayed_add;
         logical_ff     <= nxt_logical;
         extend_ff      <= nxt_extend;
         restore_x_ff   <= nxt_restore_x;
         final_ff       <= nxt_final;
         a_shift_ff     <= nxt_a_shift;
         q_shift_ff     <= nxt_q_shift;
      end
   end

   // Registered outputs
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         resume_ff     <= 1'b0;
         wait_shift_ff <= 1'b0;
         busy_ff       <= 1'b0;
         prdata_ff     <= RST_WORD;
         pready_ff     <= 1'b0;
         pslverr_ff    <= 1'b0;
      end else begin
         resume_ff     <= nxt_resume;
         wait_shift_ff <= nxt_wait_shift;
         busy_ff       <= nxt_busy;
         prdata_ff     <= nxt_prdata;
         pready_ff     <= apb_setup;
         pslverr_ff    <= nxt_pslverr;
      end
   end

   assign O_RESUME     = resume_ff;
   assign O_WAIT_SHIFT = wait_shift_ff;
   assign O_BUSY       = busy_ff;
   assign O_PRDATA     = prdata_ff;
   assign O_PREADY     = pready_ff;
   assign O_PSLVERR    = pslverr_ff;
endmodule

// >>> src/mas_pkg.sv
// Package: widths, register map, status layout and step codes of the sequencer
package mas_pkg;
   localparam int ACC_W = 72;
   localparam int Q_W   = 36;
   localparam int SC_W  = 7;

   ////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [7:0] OFS_A_LO   = 8'h00;
   localparam logic [7:0] OFS_A_MID  = 8'h04;
   localparam logic [7:0] OFS_A_HI   = 8'h08;
   localparam logic [7:0] OFS_Q_LO   = 8'h0c;
   localparam logic [7:0] OFS_Q_HI   = 8'h10;
   localparam logic [7:0] OFS_X_LO   = 8'h14;
   localparam logic [7:0] OFS_X_HI   = 8'h18;
   localparam logic [7:0] OFS_SC     = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [ACC_W-1:0] RST_ACC  = 72'h0;
   localparam logic [Q_W-1:0]   RST_Q    = 36'h0;
   localparam logic [Q_W-1:0]   RST_X    = 36'h0;
   localparam logic [SC_W-1:0]  RST_SC   = 7'h00;
   localparam logic [31:0]      RST_WORD = 32'h0;

   // Shift counter values that steer the shift sequences
   localparam logic [SC_W-1:0] SC_ZERO = 7'h00;
   localparam logic [SC_W-1:0] SC_LAST = 7'h01;
   localparam logic [SC_W-1:0] SC_STEP = 7'h01;

   // Status word field positions
   localparam int ST_DELAYED_ADD = 0;
   localparam int ST_LOGICAL     = 1;
   localparam int ST_EXTEND      = 2;
   localparam int ST_RESTORE_X   = 3;
   localparam int ST_FINAL       = 4;
   localparam int ST_A_SHIFT     = 5;
   localparam int ST_Q_SHIFT     = 6;
   localparam int ST_BUSY        = 7;
   localparam int ST_STEP_LSB    = 8;

   typedef enum logic [2:0] {
      STEP_IDLE = 3'b000,
      STEP_1    = 3'b001,
      STEP_2    = 3'b010,
      STEP_3    = 3'b011,
      STEP_4    = 3'b100,
      STEP_5    = 3'b101,
      STEP_6    = 3'b110
   } mas_step_e;
endpackage

// >>> src/mas_dp_if.sv
// Interface between the sequencer and its adder and rotator datapath
interface mas_dp_if;
   import mas_pkg::*;
   logic [ACC_W-1:0] acc;
   logic [Q_W-1:0]   addend;
   logic [Q_W-1:0]   qreg;
   logic [ACC_W-1:0] acc_sum;
   logic [ACC_W-1:0] acc_rot;
   logic [Q_W-1:0]   q_rot;

   modport seq (output acc, output addend, output qreg,
                input acc_sum, input acc_rot, input q_rot);
   modport dp  (input acc, input addend, input qreg,
                output acc_sum, output acc_rot, output q_rot);
endinterface

// >>> src/mas_datapath.sv
// Datapath: ones' complement add of a positive 36-bit value, left rotations
module mas_datapath
   import mas_pkg::*;
(
   mas_dp_if.dp dp
);
   logic [ACC_W:0]   raw_sum;
   logic [ACC_W-1:0] carry_in;

   // Addend is zero extended, so it always counts as positive
   assign raw_sum    = {1'b0, dp.acc} + {{(ACC_W-Q_W+1){1'b0}}, dp.addend};
   // End-around carry keeps the ones' complement sum exact
   assign carry_in   = {{(ACC_W-1){1'b0}}, raw_sum[ACC_W]};
   assign dp.acc_sum = raw_sum[ACC_W-1:0] + carry_in;
   assign dp.acc_rot = {dp.acc[ACC_W-2:0], dp.acc[ACC_W-1]};
   assign dp.q_rot   = {dp.qreg[Q_W-2:0], dp.qreg[Q_W-1]};
endmodule

// >>> verif/mas_sequencer_assertions.sv
// Checker: port timing of the sequencer
module mas_sequencer_assertions (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RESETN,
   // Bus and commands
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_INIT_LOGICAL,
   input wire logic I_INIT_SHIFT_A,
   input wire logic I_INIT_SHIFT_Q,
   input wire logic I_CTL_CLOCK,
   // Answers
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic O_RESUME,
   input wire logic O_WAIT_SHIFT,
   input wire logic O_BUSY
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESETN);
   a_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("ready late");
   a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready held");
   a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
      else $error("error without ready");
   a_wait_cause: assert property (O_WAIT_SHIFT |->
      $past(I_INIT_SHIFT_A || I_INIT_SHIFT_Q))
      else $error("wait without shift start");
   a_wait_single: assert property (O_WAIT_SHIFT |=> !O_WAIT_SHIFT)
      else $error("wait held");
   a_wait_busy: assert property (O_WAIT_SHIFT |-> O_BUSY)
      else $error("wait while idle");
   a_resume_cause: assert property (O_RESUME |-> $past(I_CTL_CLOCK && O_BUSY))
      else $error("resume without pulse");
   a_busy_start: assert property ($rose(O_BUSY) |->
      $past(I_INIT_LOGICAL || I_INIT_SHIFT_A || I_INIT_SHIFT_Q))
      else $error("busy without command");
endmodule

// >>> verif/mas_ctc_model.sv
// Command timing control model: commands, count loads, controlled pulses
module mas_ctc_model (
   // Clock
   input  wire logic                 i_clk,
   // Commands
   output logic                      o_init_logical,
   output logic                      o_extend_seq,
   output logic                      o_init_shift_a,
   output logic                      o_init_shift_q,
   output logic                      o_ctl_clock,
   output logic                      o_sc_load,
   output logic [mas_pkg::SC_W-1:0] o_sc_value
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {o_init_logical, o_extend_seq, o_init_shift_a, o_init_shift_q} = 4'h0;
      {o_ctl_clock, o_sc_load} = 2'h0;
      o_sc_value = '0;
   end
   task automatic start(input int kind);
      o_init_logical <= (kind == 0);
      o_extend_seq <= (kind == 0);
      o_init_shift_a <= (kind == 1);
      o_init_shift_q <= (kind == 2);
      @(posedge i_clk);
      {o_init_logical, o_extend_seq, o_init_shift_a, o_init_shift_q} <= 4'h0;
   endtask
   task automatic load(input logic [mas_pkg::SC_W-1:0] k);
      o_sc_value <= k;
      o_sc_load <= 1'b1;
      @(posedge i_clk);
      o_sc_load <= 1'b0;
      // Stale count must not be relied upon
      o_sc_value <= ~k;
   endtask
   task automatic pulses(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         o_ctl_clock <= 1'b1;
         @(posedge i_clk);
         o_ctl_clock <= 1'b0;
         repeat (gap) @(posedge i_clk);
      end
   endtask
endmodule

// >>> verif/testbench.sv
// Testbench: APB master, scenario tasks and verdict
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
   import mas_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        il, ex, sa, sq, cc, ld, resume, wait_shift, busy;
   logic [SC_W-1:0] scv;
   int          mismatches = 0, n_tests = 0, n_resume = 0, n_wait = 0;
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      n_resume += (resume === 1'b1);
      n_wait += (wait_shift === 1'b1);
   end
   mas_sequencer mas_sequencer_inst (.I_MCLK(mclk), .I_RESETN(resetn), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INIT_LOGICAL(il),
      .I_EXTEND_SEQ(ex), .I_INIT_SHIFT_A(sa), .I_INIT_SHIFT_Q(sq), .I_CTL_CLOCK(cc),
      .I_SC_LOAD(ld), .I_SC_VALUE(scv), .O_RESUME(resume), .O_WAIT_SHIFT(wait_shift),
      .O_BUSY(busy));
   mas_ctc_model mas_ctc_model_inst (.i_clk(mclk), .o_init_logical(il), .o_extend_seq(ex),
      .o_init_shift_a(sa), .o_init_shift_q(sq), .o_ctl_clock(cc), .o_sc_load(ld),
      .o_sc_value(scv));
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rw(input logic w, input logic [7:0] b, input int nw, inout logic [95:0] v);
      logic [31:0] d;
      logic e;
      for (int i = 0; i < nw; i++) begin
         apb(w, b + 8'(4 * i), v[32*i +: 32], d, e);
         if (!w) v[32*i +: 32] = d;
      end
      v &= (96'h1 << (nw == 3 ? ACC_W : Q_W)) - 96'h1;
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic e;
      for (int a = 0; a <= 32; a += 4) begin
         apb(1'b0, 8'(a), 32'h0, d, e);
         `CHK("reset value", 33'h0, {e, d});
      end
      apb(1'b0, 8'h24, 32'h0, d, e);
      `CHK("unmapped", 33'h100000000, {e, d});
      apb(1'b1, OFS_STATUS, 32'hffffffff, d, e);
      apb(1'b0, OFS_STATUS, 32'h0, d, e);
      `CHK("status read-only", 32'h0, d);
      $display("test regs done");
   endtask
   task automatic t_logical(input logic fresh, input logic [71:0] a, input logic [35:0] q, x);
      logic [95:0] v;
      logic [31:0] st;
      logic e;
      logic [35:0] xe;
      int r0;
      // Without fresh, A and Q are what the previous sequence left
      if (fresh) begin
         v = 96'(a);
         rw(1'b1, OFS_A_LO, 3, v);
         v = 96'(q);
         rw(1'b1, OFS_Q_LO, 2, v);
      end
      v = 96'(x);
      rw(1'b1, OFS_X_LO, 2, v);
      r0 = n_resume;
      mas_ctc_model_inst.start(0);
      rw(1'b0, OFS_X_LO, 2, v);
      `CHK("masked x", 96'(x & q), v);
      apb(1'b0, OFS_STATUS, 32'h0, st, e);
      `CHK("start flags", 3'b111, st[2:0]);
      for (int k = 1; k <= 6; k++) begin
         mas_ctc_model_inst.pulses(1, 1);
         xe = (k == 1) ? x & q : (k == 3) ? '1 : (k == 4) ? q : (k == 5) ? ~q : '0;
         rw(1'b0, OFS_X_LO, 2, v);
         `CHK("x step", 96'(xe), v);
         apb(1'b0, OFS_STATUS, 32'h0, st, e);
         `CHK("step flags", {k < 6, k < 4, k == 2, k == 5, 1'b0}, {st[ST_LOGICAL], st[ST_EXTEND],
            st[ST_RESTORE_X], st[ST_FINAL], st[ST_DELAYED_ADD]});
         `CHK("step code", 3'(k < 6 ? k + 1 : 0), st[ST_STEP_LSB +: 3]);
         `CHK("resume", r0 + (k == 6), n_resume);
      end
      rw(1'b0, OFS_A_LO, 3, v);
      `CHK("sum", 96'(a + 72'(x & q)), v);
      rw(1'b0, OFS_Q_LO, 2, v);
      `CHK("mask left", 96'(36'(~q)), v);
      $display("test logical done");
   endtask
   task automatic t_shift(input int kind, k, gap, input logic [95:0] val);
      logic [95:0] v;
      logic [31:0] st;
      logic e;
      int w, w0, r0;
      w = (kind == 1) ? ACC_W : Q_W;
      v = val;
      rw(1'b1, kind == 1 ? OFS_A_LO : OFS_Q_LO, w / 32 + 1, v);
      mas_ctc_model_inst.load(7'(k));
      w0 = n_wait;
      r0 = n_resume;
      mas_ctc_model_inst.start(kind);
      repeat (2) @(posedge mclk);
      `CHK("wait", w0 + (k != 0), n_wait);
      `CHK("busy", k != 0, busy);
      apb(1'b0, OFS_STATUS, 32'h0, st, e);
      `CHK("active", {kind == 1 && k != 0, kind == 2 && k != 0},
         {st[ST_A_SHIFT], st[ST_Q_SHIFT]});
      mas_ctc_model_inst.pulses(k, gap);
      repeat (2) @(posedge mclk);
      `CHK("resume", r0 + (k != 0), n_resume);
      rw(1'b0, kind == 1 ? OFS_A_LO : OFS_Q_LO, w / 32 + 1, v);
      `CHK("rotated", ((val << k) | (val >> (w - k))) & ((96'h1 << w) - 96'h1),
         v);
      apb(1'b0, OFS_SC, 32'h0, st, e);
      `CHK("count left", 32'h0, st);
      $display("test shift done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      t_regs();
      // Substitute: cleared A, second pass reuses the inverted mask; then masked add
      t_logical(1'b1, 72'h0, 36'h0f0f0f0f0, 36'h123456789);
      t_logical(1'b0, 72'h020406080, 36'hf0f0f0f0f, 36'h9abcdef01);
      t_logical(1'b1, 72'h10305070, 36'hf0f0f0f0f, 36'h9abcdef01);
      t_shift(1, 0, 1, 96'h5a5a5a5a5a5a5a5a5a);
      t_shift(1, 1, 1, 96'h800000000000000001);
      t_shift(1, 71, 1, 96'hc00000000123456789);
      t_shift(2, 4, 3, 96'h912345678);
      t_shift(2, 35, 1, 96'h800000001);
      end_sim();
   end
endmodule
bind mas_sequencer mas_sequencer_assertions mas_sequencer_assertions_inst (
   .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_INIT_LOGICAL(I_INIT_LOGICAL), .I_INIT_SHIFT_A(I_INIT_SHIFT_A),
   .I_INIT_SHIFT_Q(I_INIT_SHIFT_Q), .I_CTL_CLOCK(I_CTL_CLOCK), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_RESUME(O_RESUME), .O_WAIT_SHIFT(O_WAIT_SHIFT), .O_BUSY(O_BUSY));
